// *** tcsp_consts.svh ***
// Constants for the touch controller two-wire slave port
`ifndef TCSP_CONSTS_SVH
`define TCSP_CONSTS_SVH
`define TCSP_BASE_ADDR 7'h4C
`define TCSP_ADDR_MIN 7'h08
`define TCSP_ADDR_MAX 7'h77
`define TCSP_BITS_PER_BYTE 4'h8
`define TCSP_NUM_REGS 16
`define TCSP_REG_AW 4
`endif

// *** tcsp_master.sv ***
// Two-wire bus master model facing the slave port
module tcsp_master (
   // Bus lines, a one releases the line to its pull-up
   output logic scl_o,
   output logic sda_o,
   input wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic start();
      #50 sda_o = 1'b0;
      #150 scl_o = 1'b0;
   endtask
   task automatic stop();
      #25 sda_o = 1'b0;
      #125 scl_o = 1'b1;
      #100 sda_o = 1'b1;
      #200;
   endtask
   // one bit per pulse, sampled midway through the high phase
   task automatic bit_x(input logic b, output logic r);
      #25 sda_o = b;
      #125 scl_o = 1'b1;
      #25 r = sda_i;
      #25 scl_o = 1'b0;
   endtask
   // eight bits then the acknowledge slot
   task automatic wr_byte(input logic [7:0] v, output logic ack_n);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(v[i], r);
      bit_x(1'b1, ack_n);
   endtask
   task automatic rd_byte(input logic ack_n, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         v = {v[6:0], r};
      end
      bit_x(ack_n, r);
   endtask
endmodule

// *** tcsp_pkg.sv ***
// Types for the touch controller two-wire slave port
package tcsp_pkg;
   typedef enum logic [5:0] {
      TCSP_IDLE = 6'b000001,
      TCSP_ADDR = 6'b000010,
      TCSP_AACK = 6'b000100,
      TCSP_RECV = 6'b001000,
      TCSP_WACK = 6'b010000,
      TCSP_SEND = 6'b100000
   } tcsp_state_e;
endpackage

// *** tcsp_regmem.sv ***
// Small register memory written and read by the serial port
module tcsp_regmem (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Write side
   input wire logic wr_en_i,
   input wire logic [3:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   // Read side
   input wire logic [3:0] rd_addr_i,
   output logic [7:0] rd_data_o
);
   logic [7:0] mem_r [0:15];

   // Storage words, cleared by reset
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_word
         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               mem_r[g] <= 8'h00;
            end else if (wr_en_i && (wr_addr_i == 4'(g))) begin
               mem_r[g] <= wr_data_i;
            end
         end
      end
   endgenerate

   // Registered read data
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= mem_r[rd_addr_i];
      end
   end
endmodule

// *** tcsp_slave.sv ***
// Two-wire serial slave port of the touch controller
// How it works
// - Reset low abandons transfer, clears port state but keeps register memory
// - Interrupt output open-drain, active low only
// - Select pin picks address 0x4C or 0x4D
// - Base address fixed, variant within allowed range
// - Start, address, command, data bytes, stop
// - Data falling while clock high is start
// - Data rising while clock high is stop
// - Both lines released and high when idle
// - One bit per clock, stable while high
// - Ninth clock carries acknowledge, held low
// - Device acknowledges its own address and every byte written to it
// - Eighth bit gives direction, one is read
// - Always watch for start plus own address
// - Data open-drain, clock only an input
// - After reset stay idle until next start
// - First written byte is the command byte
`include "tcsp_consts.svh"
module tcsp_slave #(
   parameter logic [6:0] BASE_ADDR = `TCSP_BASE_ADDR
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Device reset pin, active low
   input wire logic rst_pin_n_i,
   // Serial clock, input only
   input wire logic scl_i,
   // Serial data, open drain
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Address strap
   input wire logic address_select_pin_i,
   // Interrupt, open drain
   input wire logic event_i,
   output logic irq_o,
   output logic irq_oe_n_o,
   // Status
   output logic busy_o,
   output logic [7:0] command_o
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [2:0] scl_sync_r, sda_sync_r, rst_sync_r, sel_sync_r;
   logic scl_r, sda_r, rstn_r, sel_r;

   // Three flops per pin
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
         rst_sync_r <= 3'h7;
         sel_sync_r <= 3'h0;
      end else begin
         scl_sync_r <= {scl_sync_r[1:0], scl_i};
         sda_sync_r <= {sda_sync_r[1:0], sda_i};
         rst_sync_r <= {rst_sync_r[1:0], rst_pin_n_i};
         sel_sync_r <= {sel_sync_r[1:0], address_select_pin_i};
      end
   end

   // Accept a level once second and third stages agree
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         rstn_r <= 1'b1;
         sel_r <= 1'b0;
      end else begin
         if (scl_sync_r[1] == scl_sync_r[2]) scl_r <= scl_sync_r[2];
         if (sda_sync_r[1] == sda_sync_r[2]) sda_r <= sda_sync_r[2];
         if (rst_sync_r[1] == rst_sync_r[2]) rstn_r <= rst_sync_r[2];
         if (sel_sync_r[1] == sel_sync_r[2]) sel_r <= sel_sync_r[2];
      end
   end

   // ------------------------------------------------------------
   // Bus events
   // ------------------------------------------------------------
   logic scl_q_r, sda_q_r;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_r;
         sda_q_r <= sda_r;
      end
   end

   wire scl_rise = scl_r && !scl_q_r;
   wire scl_fall = !scl_r && scl_q_r;
   wire start_det = scl_r && scl_q_r && sda_q_r && !sda_r;
   wire stop_det = scl_r && scl_q_r && !sda_q_r && sda_r;
   wire soft_clr = !rstn_r;
   wire [6:0] own_addr = {BASE_ADDR[6:1], sel_r};

   // ------------------------------------------------------------
   // Transfer state machine
   // ------------------------------------------------------------
   tcsp_pkg::tcsp_state_e state_r, state_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [3:0] bit_cnt_r, bit_cnt_nxt;
   logic rnw_r, rnw_nxt;
   logic first_r, first_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic sda_low_r, sda_low_nxt;
   logic acked_r, acked_nxt;
   logic wr_en;
   logic [7:0] rd_data;

   // Next state and shift logic
   // start, address, bytes, stop
   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      bit_cnt_nxt = bit_cnt_r;
      rnw_nxt = rnw_r;
      first_nxt = first_r;
      cmd_nxt = cmd_r;
      sda_low_nxt = sda_low_r;
      acked_nxt = 1'b0;
      wr_en = 1'b0;
      if (start_det) begin
         state_nxt = tcsp_pkg::TCSP_ADDR;
         bit_cnt_nxt = 4'h0;
         sda_low_nxt = 1'b0;
      end else if (stop_det) begin
         state_nxt = tcsp_pkg::TCSP_IDLE;
         sda_low_nxt = 1'b0;
      end else begin
         case (state_r)
            tcsp_pkg::TCSP_IDLE: begin
               sda_low_nxt = 1'b0;
            end
            tcsp_pkg::TCSP_ADDR, tcsp_pkg::TCSP_RECV: begin
               if (scl_rise) begin
                  shift_nxt = {shift_r[6:0], sda_r};
                  bit_cnt_nxt = 4'(bit_cnt_r + 4'h1);
               end else if (scl_fall && bit_cnt_r == `TCSP_BITS_PER_BYTE) begin
                  bit_cnt_nxt = 4'h0;
                  if (state_r == tcsp_pkg::TCSP_ADDR) begin
                     rnw_nxt = shift_r[0];
                     if (shift_r[7:1] == own_addr) begin
                        state_nxt = tcsp_pkg::TCSP_AACK;
                        sda_low_nxt = 1'b1;
                        first_nxt = 1'b1;
                        acked_nxt = 1'b1;
                     end else begin
                        state_nxt = tcsp_pkg::TCSP_IDLE;
                     end
                  end else begin
                     state_nxt = tcsp_pkg::TCSP_AACK;
                     sda_low_nxt = 1'b1;
                     if (first_r) begin
                        cmd_nxt = shift_r;
                        first_nxt = 1'b0;
                     end else begin
                        wr_en = 1'b1;
                     end
                  end
               end
            end
            tcsp_pkg::TCSP_AACK: begin
               if (scl_fall) begin
                  if (rnw_r) begin
                     state_nxt = tcsp_pkg::TCSP_SEND;
                     shift_nxt = rd_data;
                     sda_low_nxt = !rd_data[7];
                     bit_cnt_nxt = 4'h1;
                  end else begin
                     state_nxt = tcsp_pkg::TCSP_RECV;
                     sda_low_nxt = 1'b0;
                  end
               end
            end
            tcsp_pkg::TCSP_SEND: begin
               if (scl_fall) begin
                  if (bit_cnt_r == `TCSP_BITS_PER_BYTE) begin
                     state_nxt = tcsp_pkg::TCSP_WACK;
                     sda_low_nxt = 1'b0;
                     cmd_nxt = 8'(cmd_r + 8'h01);
                  end else begin
                     // change data only while clock low
                     shift_nxt = {shift_r[6:0], 1'b0};
                     sda_low_nxt = !shift_r[6];
                     bit_cnt_nxt = 4'(bit_cnt_r + 4'h1);
                  end
               end
            end
            tcsp_pkg::TCSP_WACK: begin
               // master acknowledge: low continues, high ends
               if (scl_rise) begin
                  rnw_nxt = !sda_r;
               end else if (scl_fall) begin
                  if (rnw_r) begin
                     state_nxt = tcsp_pkg::TCSP_SEND;
                     shift_nxt = rd_data;
                     sda_low_nxt = !rd_data[7];
                     bit_cnt_nxt = 4'h1;
                  end else begin
                     state_nxt = tcsp_pkg::TCSP_IDLE;
                  end
               end
            end
            default: state_nxt = tcsp_pkg::TCSP_IDLE;
         endcase
      end
   end

   // State registers, cleared by reset pin
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_r <= tcsp_pkg::TCSP_IDLE;
         shift_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         rnw_r <= 1'b0;
         first_r <= 1'b0;
         cmd_r <= 8'h00;
         sda_low_r <= 1'b0;
         acked_r <= 1'b0;
      end else if (soft_clr) begin
         state_r <= tcsp_pkg::TCSP_IDLE;
         shift_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         rnw_r <= 1'b0;
         first_r <= 1'b0;
         cmd_r <= 8'h00;
         sda_low_r <= 1'b0;
         acked_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         rnw_r <= rnw_nxt;
         first_r <= first_nxt;
         cmd_r <= (wr_en) ? 8'(cmd_r + 8'h01) : cmd_nxt;
         sda_low_r <= sda_low_nxt;
         acked_r <= acked_nxt;
      end
   end

   // ------------------------------------------------------------
   // Register memory
   // ------------------------------------------------------------
   tcsp_regmem u_mem (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .wr_en_i(wr_en),
      .wr_addr_i(cmd_r[3:0]),
      .wr_data_i(shift_r),
      .rd_addr_i(cmd_r[3:0]),
      .rd_data_o(rd_data)
   );

   // ------------------------------------------------------------
   // Interrupt
   // ------------------------------------------------------------
   logic irq_pend_r;
   // Event sets, address acknowledge clears; set wins
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_pend_r <= 1'b0;
      end else if (event_i) begin
         irq_pend_r <= 1'b1;
      end else if (acked_r || soft_clr) begin
         irq_pend_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   // data only pulled low, released otherwise
   assign sda_o = 1'b0;
   assign sda_oe_n_o = !sda_low_r;
   assign irq_o = 1'b0;
   assign irq_oe_n_o = !irq_pend_r;
   assign busy_o = (state_r != tcsp_pkg::TCSP_IDLE);
   assign command_o = cmd_r;
endmodule

// *** tcsp_slave_checker.sv ***
// Concurrent checks on the slave port pins
module tcsp_slave_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Pins and status
   input wire logic rst_pin_n_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic event_i,
   input wire logic irq_o,
   input wire logic irq_oe_n_o,
   input wire logic busy_o,
   input wire logic [7:0] command_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Open drain and idle release
   sda_const_a: assert property (sda_o == 1'b0) else $error("data value not low");
   irq_const_a: assert property (irq_o == 1'b0) else $error("irq value not low");
   idle_release_a: assert property (!busy_o && $past(!busy_o) |-> sda_oe_n_o)
      else $error("data driven while idle");
   drive_busy_a: assert property ($fell(sda_oe_n_o) |-> busy_o)
      else $error("data driven outside transfer");
   // Pin reset, interrupt and command
   pin_reset_a: assert property (!rst_pin_n_i [*8] |-> !busy_o && command_o == 8'h00
      && sda_oe_n_o && irq_oe_n_o) else $error("pin reset left state");
   irq_raise_a: assert property (event_i && rst_pin_n_i |-> ##[1:3] !irq_oe_n_o)
      else $error("event not signalled");
   irq_clear_a: assert property ($rose(irq_oe_n_o) |-> busy_o || !rst_pin_n_i)
      else $error("irq cleared outside access");
   cmd_change_a: assert property (!$stable(command_o) |-> busy_o || $past(busy_o)
      || !rst_pin_n_i) else $error("command changed while idle");
   ack_c: cover property ($fell(sda_oe_n_o));
   irq_c: cover property ($fell(irq_oe_n_o));
   rst_c: cover property (!rst_pin_n_i [*8]);
endmodule
bind tcsp_slave tcsp_slave_checker u_chk (.clk_i(clk_i), .reset_i(reset_i),
   .rst_pin_n_i(rst_pin_n_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .event_i(event_i),
   .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o), .busy_o(busy_o), .command_o(command_o));

// *** tcsp_slave_tb.sv ***
// Self-checking bench for the touch controller slave port
module tcsp_slave_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] BASE = 7'h4C;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic rst_pin_n, strap, event_p, m_scl, m_sda, sda_w, k;
   logic sda_o, sda_oe_n_o, irq_o, irq_oe_n_o, busy_o;
   logic [7:0] command_o, d;
   int failures = 0;
   int comparisons = 0;
   int mem[16];
   int ptr = 0;
   always #12.5 clk_i = ~clk_i;
   // Wired AND of the open-drain data line
   assign sda_w = m_sda & (sda_oe_n_o | sda_o);
   tcsp_slave #(.BASE_ADDR(BASE)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
      .rst_pin_n_i(rst_pin_n), .scl_i(m_scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o), .address_select_pin_i(strap), .event_i(event_p),
      .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o), .busy_o(busy_o), .command_o(command_o));
   tcsp_master u_master (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda_w));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (failures == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Write transfer; ok low means the address is foreign
   task automatic xfer_wr(input logic [6:0] a, input logic [7:0] c, input int n, input logic ok);
      logic [7:0] v;
      u_master.start();
      u_master.wr_byte({a, 1'b0}, k);
      check({7'h00, k}, {7'h00, ~ok});
      u_master.wr_byte(c, k);
      check({7'h00, k}, {7'h00, ~ok});
      if (ok) ptr = c;
      for (int i = 0; i < n; i++) begin
         v = 8'($urandom);
         u_master.wr_byte(v, k);
         check({7'h00, k}, {7'h00, ~ok});
         if (ok) begin
            mem[ptr % 16] = v;
            ptr = (ptr + 1) % 256;
         end
      end
      u_master.stop();
      check(command_o, 8'(ptr));
   endtask
   // Read transfer from the stored pointer, nack on the last byte
   task automatic xfer_rd(input logic [6:0] a, input int n);
      u_master.start();
      u_master.wr_byte({a, 1'b1}, k);
      check({7'h00, k}, 8'h00);
      for (int i = 0; i < n; i++) begin
         u_master.rd_byte(i == n - 1, d);
         check(d, 8'(mem[ptr % 16]));
         ptr = (ptr + 1) % 256;
      end
      u_master.stop();
      check(command_o, 8'(ptr));
   endtask
   initial begin
      rst_pin_n = 1'b1;
      strap = 1'b0;
      event_p = 1'b0;
      d = 8'($urandom(32'h8166));
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      check({4'h0, sda_oe_n_o, irq_oe_n_o, busy_o, irq_o}, 8'h0C);
      check(command_o, 8'h00);
      for (int s = 0; s < 2; s++) begin
         strap = s[0];
         repeat (8) @(negedge clk_i);
         d = (s == 0) ? 8'h0E : 8'($urandom);
         xfer_wr({BASE[6:1], strap}, d, 3, 1'b1);
         xfer_wr({BASE[6:1], strap}, d, 0, 1'b1);
         xfer_rd({BASE[6:1], strap}, 3);
         xfer_wr({BASE[6:1], ~strap}, 8'h05, 1, 1'b0);
      end
      u_master.start();
      u_master.wr_byte({BASE[6:1], strap, 1'b0}, k);
      check({7'h00, busy_o}, 8'h01);
      rst_pin_n = 1'b0;
      repeat (8) @(negedge clk_i);
      check({busy_o, command_o[6:0]}, 8'h00);
      rst_pin_n = 1'b1;
      ptr = 0;
      u_master.stop();
      xfer_rd({BASE[6:1], strap}, 1);
      event_p = 1'b1;
      @(posedge clk_i);
      @(negedge clk_i);
      event_p = 1'b0;
      repeat (4) @(negedge clk_i);
      check({7'h00, irq_oe_n_o}, 8'h00);
      xfer_wr({BASE[6:1], ~strap}, 8'h01, 0, 1'b0);
      check({7'h00, irq_oe_n_o}, 8'h00);
      xfer_rd({BASE[6:1], strap}, 1);
      check({7'h00, irq_oe_n_o}, 8'h01);
      test_done();
   end
   // Hang guard
   initial begin
      #1000000;
      failures++;
      test_done();
   end
endmodule
